// file: rtl/adcsq_top.sv
// sequencer control, status flags, result slots and apb register file
// **********************************
// Overview of operation
// - control write restarts, aborting and clearing flags
// - control register read/write any time
// - eight-select picks four or eight conversions
// - scan repeats sequences, else halt
// - single mode converts one selected channel
// - multichannel steps consecutive group channels
// - four-mode groups: inputs, reserved, references
// - eight-mode: inputs or references in slots 4-7
// - midpoint always converts to 80 (half scale forced)
// - sequence flag set after first sequence
// - normal clear: control write clears sequence flag
// - fast clear: reading result slot 0 clears it
// - three-bit counter shows next slot
// - per-slot done flags sticky until cleared
// - fast clear: result read clears flag
// - normal: status then result read clears
// - status writable only in special mode
// - test registers zero unless special mode
// - test bytes read/load approximation bits
// - fast clear on any result access
// - scan restarts sequence automatically
// - ten-bit low bits in result low 7:6
// **********************************
`timescale 1ns/1ps
module adcsq_top
   import adcsq_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic cmp_i,
   output logic [3:0] mux_sel_o,
   output logic mux_ref_o,
   output logic [9:0] sar_o,
   output logic busy_o
);
   // ******************************
   // bus decode
   // ******************************
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] idx;
   logic aligned;
   logic [7:0] wbyte;
   assign acc = psel_i & penable_i & pready_o;
   assign wr = acc & pwrite_i;
   assign rd = acc & ~pwrite_i;
   assign idx = paddr_i[9:2];
   assign aligned = (paddr_i[1:0] == 2'b00) & ~paddr_i[11] & ~paddr_i[10];
   assign wbyte = pwdata_i[7:0];
   function automatic logic hit(input logic [7:0] a, input logic [7:0] i, input logic ok);
      hit = ok & (a == i);
   endfunction
   logic sel_ctl, sel_stat, sel_done, sel_th, sel_tl, sel_c2, sel_mode, sel_res, mapped;
   assign sel_ctl = hit(idx, ADCSQ_IDX_SEQ_CTRL, aligned);
   assign sel_stat = hit(idx, ADCSQ_IDX_SEQ_STAT, aligned);
   assign sel_done = hit(idx, ADCSQ_IDX_DONE_STAT, aligned);
   assign sel_th = hit(idx, ADCSQ_IDX_TEST_HI, aligned);
   assign sel_tl = hit(idx, ADCSQ_IDX_TEST_LO, aligned);
   assign sel_c2 = hit(idx, ADCSQ_IDX_CTRL_TWO, aligned);
   assign sel_mode = hit(idx, ADCSQ_IDX_MODE, aligned);
   assign sel_res = aligned & (idx >= ADCSQ_IDX_RES_BASE) & (idx <= ADCSQ_IDX_RES_LAST);
   assign mapped = sel_ctl | sel_stat | sel_done | sel_th | sel_tl | sel_c2 | sel_mode
                   | sel_res;
   // ******************************
   // registers
   // ******************************
   logic [7:0] ctl_reg;
   logic [1:0] c2_reg;
   logic special_reg;
   logic scf_reg;
   logic [7:0] ccf_reg;
   logic [7:0] ccf_next;
   logic scf_next;
   logic [7:0] armed_reg;
   logic [2:0] cnt_reg;
   logic first_reg;
   adcsq_state_t st_reg;
   adcsq_state_t st_next;
   logic ffc, ten, eight, scan, multichannel_enable;
   assign ffc = c2_reg[1];
   assign ten = c2_reg[0];
   assign eight = ctl_reg[ADCSQ_CTL_EIGHT];
   assign scan = ctl_reg[ADCSQ_CTL_SCAN];
   assign multichannel_enable = ctl_reg[ADCSQ_CTL_MULTICHANNEL_ENABLE];
   logic ctl_wr;
   assign ctl_wr = wr & sel_ctl;
   // ******************************
   // channel selection
   // ******************************
   logic [3:0] chan;
   logic [2:0] slot;
   logic [2:0] last;
   logic [1:0] grp;
   // group taken from the upper select bits, low bits from the counter
   assign grp = eight ? {ctl_reg[3], 1'b0} : ctl_reg[3:2];
   assign chan = multichannel_enable ? (eight ? {ctl_reg[3], cnt_reg} : {grp, cnt_reg[1:0]})
                      : ctl_reg[3:0];
   assign slot = cnt_reg;
   assign last = eight ? 3'h7 : 3'h3;
   // ******************************
   // approximation engine
   // ******************************
   logic start_conv, sar_done, sar_busy, sar_load;
   logic [9:0] sar_val, sar_load_val, conv_val;
   logic is_mid;
   assign is_mid = (chan == 4'he);
   // midpoint forced to half scale: 8-bit view gives 80
   assign conv_val = is_mid ? ADCSQ_MID_CODE : sar_val;
   assign sar_load = special_reg & wr & (sel_th | sel_tl);
   assign sar_load_val = sel_th ? {wbyte, sar_val[1:0]} : {sar_val[9:2], wbyte[7:6]};
   assign start_conv = (st_reg == ADCSQ_IDLE) & (st_next == ADCSQ_CONV);
   adcsq_sar u_sar (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .start_i(start_conv),
      .abort_i(ctl_wr),
      .cmp_i(cmp_i),
      .load_i(sar_load),
      .load_val_i(sar_load_val),
      .sar_o(sar_val),
      .busy_o(sar_busy),
      .done_o(sar_done)
   );
   logic [9:0] mem_rdata;
   adcsq_result_mem u_mem (
      .clk_sys_i(clk_sys_i),
      .we_i(sar_done & ~ctl_wr),
      .waddr_i(slot),
      .wdata_i(conv_val),
      .raddr_i(paddr_i[5:3]),
      .rdata_o(mem_rdata)
   );
   // ******************************
   // sequencer
   // ******************************
   logic run_reg;
   logic seq_end;
   assign seq_end = sar_done & (cnt_reg == last);
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ADCSQ_IDLE: begin
            if (run_reg & ~ctl_wr) begin
               st_next = ADCSQ_CONV;
            end
         end
         ADCSQ_CONV: begin
            if (ctl_wr) begin
               st_next = ADCSQ_IDLE;
            end else if (sar_done) begin
               st_next = ADCSQ_STORE;
            end
         end
         ADCSQ_STORE: begin
            st_next = ADCSQ_IDLE;
         end
         default: begin
            st_next = ADCSQ_IDLE;
         end
      endcase
   end
   // ******************************
   // flags
   // ******************************
   logic [7:0] res_bit;
   logic [7:0] set_bit;
   logic stat_read_reg;
   logic res_rd;
   assign res_rd = acc & sel_res & ~pwrite_i;
   // slot is index bits 3:1, i.e. byte address bits 5:3
   assign res_bit = 8'h01 << paddr_i[5:3];
   assign set_bit = (sar_done & ~ctl_wr) ? (8'h01 << slot) : 8'h00;
   always_comb begin
      ccf_next = ccf_reg;
      scf_next = scf_reg;
      if (ffc & acc & sel_res) begin
         ccf_next = ccf_next & ~res_bit;
      end else if (~ffc & res_rd & armed_reg[paddr_i[5:3]]) begin
         ccf_next = ccf_next & ~res_bit;
      end
      if (ffc & res_rd & (paddr_i[5:3] == 3'h0)) begin
         scf_next = 1'b0;
      end
      if (special_reg & wr & sel_done) begin
         ccf_next = wbyte;
      end
      if (special_reg & wr & sel_stat) begin
         scf_next = wbyte[ADCSQ_STAT_SCF];
      end
      ccf_next = ccf_next | set_bit;
      if (seq_end & first_reg & ~ctl_wr) begin
         scf_next = 1'b1;
      end
      if (ctl_wr) begin
         ccf_next = ADCSQ_RST_FLAGS;
         scf_next = 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_reg <= ADCSQ_RST_CTRL;
         c2_reg <= 2'b00;
         special_reg <= 1'b0;
         scf_reg <= 1'b0;
         ccf_reg <= ADCSQ_RST_FLAGS;
         armed_reg <= 8'h00;
         cnt_reg <= 3'h0;
         first_reg <= 1'b0;
         run_reg <= 1'b0;
         st_reg <= ADCSQ_IDLE;
      end else begin
         st_reg <= st_next;
         scf_reg <= scf_next;
         ccf_reg <= ccf_next;
         if (ctl_wr) begin
            ctl_reg <= wbyte;
            cnt_reg <= 3'h0;
            first_reg <= 1'b1;
            run_reg <= 1'b1;
         end else if (seq_end) begin
            cnt_reg <= 3'h0;
            first_reg <= 1'b0;
            run_reg <= scan;
         end else if (sar_done) begin
            cnt_reg <= cnt_reg + 3'h1;
         end
         if (wr & sel_c2) begin
            c2_reg <= {wbyte[ADCSQ_CTL2_FFC], wbyte[ADCSQ_CTL2_TEN]};
         end
         if (wr & sel_mode) begin
            special_reg <= wbyte[ADCSQ_MODE_SPECIAL];
         end
         // a status read arms the flags set at that moment
         if (rd & sel_done) begin
            armed_reg <= ccf_reg;
         end else if (res_rd) begin
            armed_reg <= armed_reg & ~res_bit;
         end
      end
   end
   // ******************************
   // read mux and outputs
   // ******************************
   logic [7:0] rdata;
   logic [7:0] res_byte;
   logic [9:0] mem_view;
   assign mem_view = ten ? mem_rdata : {mem_rdata[9:2], 2'b00};
   assign res_byte = paddr_i[2] ? {mem_view[1:0], 6'h00} : mem_view[9:2];
   assign rdata = sel_ctl ? ctl_reg :
                  sel_stat ? {scf_reg, 4'h0, cnt_reg} :
                  sel_done ? ccf_reg :
                  sel_th ? (special_reg ? sar_val[9:2] : 8'h00) :
                  sel_tl ? (special_reg ? {sar_val[1:0], 6'h00} : 8'h00) :
                  sel_c2 ? {1'b0, c2_reg, 5'h00} :
                  sel_mode ? {7'h00, special_reg} : 8'h00;
   logic res_phase;
   assign res_phase = psel_i & ~penable_i & sel_res & ~pwrite_i;
   logic unused_busy;
   assign unused_busy = sar_busy;
   // engine register drives the pin: a second stage would make the
   // comparator judge the previous trial
   assign sar_o = sar_val;
   // result reads wait one cycle for the memory register
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         mux_sel_o <= 4'h0;
         mux_ref_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o & ~res_phase;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
         prdata_o <= {24'h0, sel_res ? res_byte : rdata};
         mux_sel_o <= chan;
         mux_ref_o <= (chan[3:2] == 2'b11);
         busy_o <= run_reg | (st_reg != ADCSQ_IDLE);
      end
   end
endmodule

// file: rtl/adcsq_pkg.sv
// package of offsets, fields and constants for the conversion sequencer
package adcsq_pkg;
   // ******************************
   // register offsets (byte addresses = 4 * index)
   // ******************************
   localparam logic [7:0] ADCSQ_IDX_SEQ_CTRL = 8'h65;
   localparam logic [7:0] ADCSQ_IDX_SEQ_STAT = 8'h66;
   localparam logic [7:0] ADCSQ_IDX_DONE_STAT = 8'h67;
   localparam logic [7:0] ADCSQ_IDX_TEST_HI = 8'h68;
   localparam logic [7:0] ADCSQ_IDX_TEST_LO = 8'h69;
   localparam logic [7:0] ADCSQ_IDX_CTRL_TWO = 8'h62;
   localparam logic [7:0] ADCSQ_IDX_MODE = 8'h6a;
   localparam logic [7:0] ADCSQ_IDX_RES_BASE = 8'h70;
   localparam logic [7:0] ADCSQ_IDX_RES_LAST = 8'h7f;
   // ******************************
   // field positions
   // ******************************
   localparam int ADCSQ_CTL_EIGHT = 6;
   localparam int ADCSQ_CTL_SCAN = 5;
   localparam int ADCSQ_CTL_MULTICHANNEL_ENABLE = 4;
   localparam int ADCSQ_STAT_SCF = 7;
   localparam int ADCSQ_CTL2_FFC = 6;
   localparam int ADCSQ_CTL2_TEN = 5;
   localparam int ADCSQ_MODE_SPECIAL = 0;
   // ******************************
   // reset values and timing
   // ******************************
   localparam logic [7:0] ADCSQ_RST_CTRL = 8'h00;
   localparam logic [7:0] ADCSQ_RST_FLAGS = 8'h00;
   localparam logic [9:0] ADCSQ_RST_SAR = 10'h000;
   localparam logic [3:0] ADCSQ_CONV_CYCLES = 4'ha;
   localparam logic [9:0] ADCSQ_MID_CODE = 10'h200;
   typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_CONV, ADCSQ_STORE} adcsq_state_t;
endpackage

// file: rtl/adcsq_result_mem.sv
// eight-slot memory of ten-bit conversion results
`timescale 1ns/1ps
module adcsq_result_mem (
   input wire logic clk_sys_i,
   input wire logic we_i,
   input wire logic [2:0] waddr_i,
   input wire logic [9:0] wdata_i,
   input wire logic [2:0] raddr_i,
   output logic [9:0] rdata_o
);
   logic [9:0] mem_reg [0:7];
   // no reset: result contents are undefined until first written
   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
   end
endmodule

// file: rtl/adcsq_sar.sv
// successive approximation engine, one bit per clock
`timescale 1ns/1ps
module adcsq_sar
   import adcsq_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic cmp_i,
   input wire logic load_i,
   input wire logic [9:0] load_val_i,
   output logic [9:0] sar_o,
   output logic busy_o,
   output logic done_o
);
   logic [3:0] bit_reg;
   logic [3:0] bit_next;
   logic [9:0] trial;
   assign bit_next = bit_reg - 4'h1;
   assign trial = sar_o | (10'h001 << bit_reg);
   // comparator answers for the trial value presented on sar_o
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sar_o <= ADCSQ_RST_SAR;
         bit_reg <= 4'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (abort_i) begin
            busy_o <= 1'b0;
         end else if (start_i) begin
            sar_o <= 10'h200;
            bit_reg <= 4'h9;
            busy_o <= 1'b1;
         end else if (busy_o) begin
            sar_o <= cmp_i ? sar_o : (sar_o & ~(10'h001 << bit_reg));
            if (bit_reg == 4'h0) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               bit_reg <= bit_next;
               sar_o <= (cmp_i ? sar_o : (sar_o & ~(10'h001 << bit_reg)))
                        | (10'h001 << bit_next);
            end
         end else if (load_i) begin
            sar_o <= load_val_i;
         end
      end
   end
   logic unused_trial;
   assign unused_trial = ^trial;
endmodule

// file: test/adcsq_top_sva.sv
// assertion checker on the sequencer top ports
`timescale 1ns/1ps
module adcsq_top_sva
   import adcsq_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic cmp_i,
   input wire logic [3:0] mux_sel_o,
   input wire logic mux_ref_o,
   input wire logic [9:0] sar_o,
   input wire logic busy_o
);
   // ***************
   // shadow state
   // ***************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   wire acc = psel_i && penable_i && pready_o;
   wire rd_acc = acc && !pwrite_i;
   wire is_ctl = paddr_i == {2'b00, ADCSQ_IDX_SEQ_CTRL, 2'b00};
   wire is_stat = paddr_i == {2'b00, ADCSQ_IDX_SEQ_STAT, 2'b00};
   wire is_test = paddr_i[11:3] == 9'h034;
   wire wr_ctl = acc && pwrite_i && is_ctl;
   wire wr_mode = acc && pwrite_i && paddr_i == {2'b00, ADCSQ_IDX_MODE, 2'b00};
   logic [7:0] ctl_reg;
   logic [2:0] age_reg;
   logic spec_reg;
   // age lets the mux settle after a restart before it is judged
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_reg <= 8'h00;
         age_reg <= 3'h0;
         spec_reg <= 1'b0;
      end else begin
         ctl_reg <= wr_ctl ? pwdata_i[7:0] : ctl_reg;
         age_reg <= wr_ctl ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
         spec_reg <= wr_mode ? pwdata_i[0] : spec_reg;
      end
   end
   // ***************
   // properties
   // ***************
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("pready held longer than one cycle");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   a_unmapped_err: assert property (acc && paddr_i == 12'h000 |-> pslverr_o)
      else $error("unmapped access not refused");
   a_ctl_starts_run: assert property (wr_ctl |-> ##[1:4] busy_o)
      else $error("control write did not start a sequence");
   a_ctl_read_back: assert property (rd_acc && is_ctl |-> prdata_o[7:0] == ctl_reg)
      else $error("control read differs from last write");
   a_four_count: assert property (rd_acc && is_stat && !ctl_reg[6] |-> !prdata_o[2])
      else $error("counter beyond four in four mode");
   a_single_chan: assert property (busy_o && age_reg == 3'h7 && !ctl_reg[4]
      |-> mux_sel_o == ctl_reg[3:0])
      else $error("single mode converts wrong channel");
   a_group_keep: assert property (busy_o && age_reg == 3'h7 && ctl_reg[4] && !ctl_reg[6]
      |-> mux_sel_o[3:2] == ctl_reg[3:2])
      else $error("multichannel left its group");
   a_ref_group: assert property (mux_ref_o |-> mux_sel_o[3:2] == 2'b11)
      else $error("reference flag outside reference group");
   a_test_zero: assert property (rd_acc && is_test && !spec_reg |-> prdata_o[7:0] == 8'h00)
      else $error("test register visible in normal mode");
   c_ctl_write: cover property (wr_ctl);
   c_ref_conv: cover property (mux_ref_o && busy_o);
   c_refused: cover property (acc && pslverr_o);
endmodule
bind adcsq_top adcsq_top_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i),
   .mux_sel_o(mux_sel_o), .mux_ref_o(mux_ref_o), .sar_o(sar_o), .busy_o(busy_o));

// file: test/adcsq_conv_model.sv
// behavioural analog inputs and comparator facing the sequencer
`timescale 1ns/1ps
module adcsq_conv_model (
   input wire logic [3:0] mux_sel_i,
   input wire logic [9:0] sar_i,
   input wire logic [6:0] base_i,
   output logic cmp_o
);
   // ***************
   // input levels
   // ***************
   logic [9:0] level;
   always_comb begin
      case (mux_sel_i)
         4'hc: level = 10'h3ff;
         4'hd: level = 10'h000;
         4'he: level = 10'h200;
         default: level = {mux_sel_i[2:0], base_i};
      endcase
   end
   // ideal comparator, no noise, so results are near exact
   assign cmp_o = level > sar_i;
endmodule

// file: test/adc_sequence_control_status_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_sequence_control_status_tb_top;
   import adcsq_pkg::*;
   // ***************
   // signals and helpers
   // ***************
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic cmp_i;
   logic [3:0] mux_sel_o;
   logic mux_ref_o;
   logic [9:0] sar_o;
   logic busy_o;
   logic [6:0] base = 7'h00;
   logic [31:0] rd;
   logic [9:0] lo;
   logic er;
   logic [7:0] runs [3];
   int fails = 0;
   int checks_done = 0;
   adcsq_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i),
      .mux_sel_o(mux_sel_o), .mux_ref_o(mux_ref_o), .sar_o(sar_o), .busy_o(busy_o));
   adcsq_conv_model u_model (.mux_sel_i(mux_sel_o), .sar_i(sar_o), .base_i(base),
      .cmp_o(cmp_i));
   always #10 clk_sys_i = ~clk_sys_i;
   function automatic logic [3:0] chan(input logic [7:0] c, input logic [2:0] sl);
      if (!c[4]) return c[3:0];
      if (!c[6]) return {c[3:2], sl[1:0]};
      return {c[3], sl};
   endfunction
   function automatic logic [7:0] lvl_hi(input logic [3:0] ch);
      logic [9:0] v;
      v = {ch[2:0], base};
      if (ch == 4'hc) v = 10'h3ff;
      if (ch == 4'hd) v = 10'h000;
      if (ch == 4'he) v = 10'h200;
      return v[9:2];
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // one code either way covers comparator rounding at bit zero
   task chk_near(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e && g !== e + 8'h01 && g !== e - 8'h01) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {2'b00, idx, 2'b00};
      pwdata_i <= {24'h0, d};
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1 && n < 40);
      if (n >= 40) fails++;
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task wait_idle;
      int n;
      repeat (4) @(posedge clk_sys_i);
      n = 0;
      while (busy_o !== 1'b0 && n < 3000) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n >= 3000) fails++;
   endtask
   // ***************
   // scenarios
   // ***************
   initial begin
      void'($urandom(8));
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      apb(1'b0, ADCSQ_IDX_SEQ_CTRL, 8'h00);
      chk8("ctl reset", ADCSQ_RST_CTRL, rd[7:0]);
      apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
      chk8("done reset", 8'h00, rd[7:0]);
      apb(1'b1, 8'h00, 8'h11);
      chk8("unmapped err", 8'h01, {7'h0, er});
      base = 7'($urandom);
      runs[0] = {5'h00, 3'($urandom)};
      runs[1] = 8'h50;
      runs[2] = 8'h1c;
      for (int r = 0; r < 3; r++) begin
         apb(1'b1, ADCSQ_IDX_SEQ_CTRL, runs[r]);
         apb(1'b0, ADCSQ_IDX_SEQ_STAT, 8'h00);
         chk8("seq flag cleared", 8'h00, {7'h0, rd[ADCSQ_STAT_SCF]});
         wait_idle;
         apb(1'b0, ADCSQ_IDX_RES_BASE, 8'h00);
         apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
         chk8("done flags", runs[r][6] ? 8'hff : 8'h0f, rd[7:0]);
         apb(1'b0, ADCSQ_IDX_SEQ_STAT, 8'h00);
         chk8("seq flag", 8'h01, {7'h0, rd[ADCSQ_STAT_SCF]});
         for (int s = 0; s < (runs[r][6] ? 8 : 4); s++) begin
            apb(1'b0, ADCSQ_IDX_RES_BASE + 8'(2 * s), 8'h00);
            chk_near("result", lvl_hi(chan(runs[r], 3'(s))), rd[7:0]);
         end
         apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
         chk8("done after reads", 8'h00, rd[7:0]);
         @(negedge clk_sys_i);
         chk8("halted", 8'h00, {7'h0, busy_o});
      end
      apb(1'b1, ADCSQ_IDX_SEQ_CTRL, 8'h50);
      repeat (30) @(posedge clk_sys_i);
      apb(1'b1, ADCSQ_IDX_SEQ_CTRL, 8'h50);
      apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
      chk8("abort clears", 8'h00, rd[7:0]);
      wait_idle;
      apb(1'b1, ADCSQ_IDX_CTRL_TWO, 8'h40);
      apb(1'b1, ADCSQ_IDX_SEQ_CTRL, 8'h02);
      wait_idle;
      apb(1'b0, ADCSQ_IDX_RES_BASE + 8'h01, 8'h00);
      apb(1'b0, ADCSQ_IDX_SEQ_STAT, 8'h00);
      chk8("fast seq clear", 8'h00, {7'h0, rd[ADCSQ_STAT_SCF]});
      apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
      chk8("fast flag clear", 8'h0e, rd[7:0]);
      apb(1'b1, ADCSQ_IDX_CTRL_TWO, 8'h20);
      apb(1'b1, ADCSQ_IDX_SEQ_CTRL, 8'h05);
      wait_idle;
      apb(1'b0, ADCSQ_IDX_RES_BASE + 8'h01, 8'h00);
      chk8("ten bit low", 8'h00, {2'b00, rd[5:0]});
      lo = {3'h5, base} - 10'h001;
      chk8("ten bit low bits", {lo[1:0], 6'h00}, rd[7:0]);
      apb(1'b0, ADCSQ_IDX_RES_BASE, 8'h00);
      chk_near("ten bit high", lvl_hi(4'h5), rd[7:0]);
      apb(1'b1, ADCSQ_IDX_CTRL_TWO, 8'h00);
      apb(1'b1, ADCSQ_IDX_SEQ_CTRL, 8'h23);
      repeat (150) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk8("scan running", 8'h01, {7'h0, busy_o});
      apb(1'b0, ADCSQ_IDX_SEQ_STAT, 8'h00);
      chk8("scan seq flag", 8'h01, {7'h0, rd[ADCSQ_STAT_SCF]});
      apb(1'b1, ADCSQ_IDX_SEQ_CTRL, 8'h00);
      wait_idle;
      apb(1'b1, ADCSQ_IDX_MODE, 8'h01);
      apb(1'b1, ADCSQ_IDX_TEST_HI, 8'ha5);
      apb(1'b0, ADCSQ_IDX_TEST_HI, 8'h00);
      chk8("test load", 8'ha5, rd[7:0]);
      apb(1'b1, ADCSQ_IDX_DONE_STAT, 8'h3c);
      apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
      chk8("special flag write", 8'h3c, rd[7:0]);
      apb(1'b1, ADCSQ_IDX_MODE, 8'h00);
      apb(1'b1, ADCSQ_IDX_DONE_STAT, 8'hff);
      apb(1'b0, ADCSQ_IDX_DONE_STAT, 8'h00);
      chk8("normal flag write", 8'h3c, rd[7:0]);
      apb(1'b0, ADCSQ_IDX_TEST_HI, 8'h00);
      chk8("test hidden", 8'h00, rd[7:0]);
      end_of_test;
   end
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      fails++;
      end_of_test;
   end
endmodule
